/* File: inc/tcd_pkg.sv */
// Constants, types and carriers for the trigger coincidence timing block
package tcd_pkg;
   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int TCD_NCH = 6;
   localparam int TCD_NSIDE = 3;
   localparam int TCD_TS_W = 16;
   localparam int TCD_TS1_W = TCD_TS_W + 1;
   localparam int TCD_DLY_W = 4;
   localparam int TCD_DLY_LEN = 16;
   localparam int TCD_CNT_W = 24;
   localparam int TCD_THR_W = 12;
   localparam int TCD_ADDR_W = 4;
   localparam int TCD_FRAME_W = TCD_ADDR_W + TCD_THR_W;
   localparam int TCD_BIT_W = 4;
   localparam int TCD_CH_W = 3;
   localparam int TCD_WIN_W = 2;
   localparam int TCD_HOLD_W = 3;
   localparam int TCD_DIV_W = 4;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam logic [TCD_HOLD_W-1:0] TCD_TRIG_SPACE = 3'h5;
   localparam logic [TCD_WIN_W-1:0] TCD_COINC_WIN = 2'h2;
   localparam logic [TCD_DIV_W-1:0] TCD_DAC_DIV = 4'h4;
   localparam logic [TCD_CH_W-1:0] TCD_LAST_CH = 3'h5;
   localparam logic [TCD_BIT_W-1:0] TCD_LAST_BIT = 4'hf;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {DAC_IDLE, DAC_LOAD, DAC_SHIFT} tcd_dac_e;
   typedef logic [TCD_NCH-1:0][TCD_DLY_W-1:0] tcd_delay_t;
   typedef logic [TCD_NCH-1:0][TCD_THR_W-1:0] tcd_thr_t;
   typedef logic [TCD_NCH-1:0][TCD_CNT_W-1:0] tcd_cnt_t;
   typedef logic [TCD_NCH-1:0][TCD_TS1_W-1:0] tcd_time_t;
   typedef struct packed {
      logic sclk;
      logic din;
      logic cs_n;
   } tcd_dac_s;
   typedef struct packed {
      logic [TCD_NCH-1:0] valid;
      tcd_time_t stamp;
   } tcd_hit_s;
endpackage : tcd_pkg

/* File: hdl/tcd_top.sv */
// Trigger coincidence timing: dual-edge sampling, alignment, trigger, counts, DAC load
// What this block does
// - Each discriminator input is sampled on both clock edges so a hit stamp has half-period steps.
// - A per-channel offset, changeable at any time, shifts each channel in time for alignment.
// - Six discriminator inputs and an accelerator clock come in, and one fast trigger goes out.
// - The trigger is formed from the three upstream and three downstream channels inside this block.
// - Per-channel hit and coincidence counts run continuously and are offered for monitoring.
// - One load writes all six comparator thresholds in turn, one frame each, through a slow serial DAC port.
// - The pixel readout stream arrives on a receiver pin and passes a three-flop synchronizer and a glitch filter.
// - Two of three upstream and two of three downstream hits must coincide, and both sides are ANDed.
// - Two trigger pulses are never closer than five clock ticks.
module tcd_top
   import tcd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [TCD_NCH-1:0] DISC_IN,
   input wire logic ACC_CLK_IN,
   input wire tcd_delay_t CH_DELAY,
   input wire tcd_thr_t THR_VALUE,
   input wire logic THR_LOAD,
   input wire logic PIX_RX_IN,
   output logic TRIG_OUT,
   output tcd_hit_s HIT,
   output tcd_cnt_t HIT_COUNT,
   output tcd_cnt_t COINC_COUNT,
   output logic [TCD_CNT_W-1:0] TRIG_COUNT,
   output tcd_dac_s DAC,
   output logic DAC_BUSY,
   output logic PIX_RX_DATA
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [TCD_NCH-1:0] rise1;
      logic [TCD_NCH-1:0] rise2;
      logic [TCD_NCH-1:0] rise3;
      logic [TCD_NCH-1:0] fall2;
      logic [TCD_NCH-1:0] fall3;
      logic [TCD_NCH-1:0] filt_rise;
      logic [TCD_NCH-1:0] filt_fall;
      logic [TCD_NCH-1:0] prev_late;
      logic [2:0] acc_sync;
      logic acc_filt;
      logic [2:0] pix_sync;
      logic pix_filt;
      logic [TCD_TS_W-1:0] ts_cnt;
      logic [TCD_NCH-1:0][TCD_DLY_LEN-1:0] dline;
      logic [TCD_NCH-1:0][TCD_WIN_W-1:0] stretch;
      logic [TCD_HOLD_W-1:0] holdoff;
      logic trig;
      tcd_hit_s hit;
      tcd_cnt_t hit_cnt;
      tcd_cnt_t coin_cnt;
      logic [TCD_CNT_W-1:0] trig_cnt;
      tcd_dac_e dac_st;
      logic [TCD_CH_W-1:0] dac_ch;
      logic [TCD_BIT_W-1:0] dac_bit;
      logic [TCD_DIV_W-1:0] dac_div;
      logic [TCD_FRAME_W-1:0] dac_shreg;
      tcd_dac_s dac;
   } tcd_state_s;

   tcd_state_s st_r;
   tcd_state_s st_nxt;
   logic [TCD_NCH-1:0] fall1_r;

   // ************************************************************
   // Falling-edge capture
   // ************************************************************
   // Only the second falling-phase stage reads this flop
   always_ff @(negedge MCLK or posedge RESET)
   begin
      if (RESET)
         fall1_r <= '0;
      else
         fall1_r <= DISC_IN;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      logic [TCD_NCH-1:0] edge_early;
      logic [TCD_NCH-1:0] edge_late;
      logic [TCD_NCH-1:0] hit_now;
      logic [TCD_NCH-1:0] dly_hit;
      logic [TCD_NCH-1:0] act;
      logic up_ok;
      logic dn_ok;
      logic fire;
      logic [TCD_THR_W-1:0] thr;
      logic [TCD_FRAME_W-1:0] frm;
      edge_early = '0;
      edge_late = '0;
      hit_now = '0;
      dly_hit = '0;
      act = '0;
      up_ok = 1'b0;
      dn_ok = 1'b0;
      fire = 1'b0;
      thr = '0;
      frm = '0;
      st_nxt = st_r;

      // Rising phase and falling phase reach stage three on the same edge
      st_nxt.rise1 = DISC_IN;
      st_nxt.rise2 = st_r.rise1;
      st_nxt.rise3 = st_r.rise2;
      st_nxt.fall2 = fall1_r;
      st_nxt.fall3 = st_r.fall2;
      st_nxt.filt_rise = (st_r.rise2 & st_r.rise3) |
                         (st_r.filt_rise & (st_r.rise2 | st_r.rise3));
      st_nxt.filt_fall = (st_r.fall2 & st_r.fall3) |
                         (st_r.filt_fall & (st_r.fall2 | st_r.fall3));
      st_nxt.acc_sync = {st_r.acc_sync[1:0], ACC_CLK_IN};
      if (st_r.acc_sync[1] == st_r.acc_sync[2])
         st_nxt.acc_filt = st_r.acc_sync[2];
      st_nxt.pix_sync = {st_r.pix_sync[1:0], PIX_RX_IN};
      if (st_r.pix_sync[1] == st_r.pix_sync[2])
         st_nxt.pix_filt = st_r.pix_sync[2];

      // Stamps count from the last accelerator clock rising edge
      if (st_nxt.acc_filt && !st_r.acc_filt)
         st_nxt.ts_cnt = '0;
      else
         st_nxt.ts_cnt = st_r.ts_cnt + 1'b1;

      // Early sample precedes late sample within one tick
      edge_early = st_r.filt_rise & ~st_r.prev_late;
      edge_late = st_r.filt_fall & ~st_r.filt_rise;
      hit_now = edge_early | edge_late;
      st_nxt.prev_late = st_r.filt_fall;
      st_nxt.hit.valid = hit_now;
      for (int i = 0; i < TCD_NCH; i++)
      begin
         if (hit_now[i])
         begin
            // Offset in whole ticks is added to the half-tick stamp
            st_nxt.hit.stamp[i] = {st_r.ts_cnt, edge_late[i] & ~edge_early[i]} +
                                  TCD_TS1_W'({CH_DELAY[i], 1'b0});
            st_nxt.hit_cnt[i] = st_r.hit_cnt[i] + 1'b1;
         end
         st_nxt.dline[i] = {st_r.dline[i][TCD_DLY_LEN-2:0], hit_now[i]};
         dly_hit[i] = st_r.dline[i][CH_DELAY[i]];
         if (dly_hit[i])
            st_nxt.stretch[i] = TCD_COINC_WIN;
         else if (st_r.stretch[i] != '0)
            st_nxt.stretch[i] = st_r.stretch[i] - 1'b1;
         act[i] = dly_hit[i] | (st_r.stretch[i] != '0);
      end

      // Two of three on each side, both sides required
      up_ok = (act[0] & act[1]) | (act[0] & act[2]) | (act[1] & act[2]);
      dn_ok = (act[3] & act[4]) | (act[3] & act[5]) | (act[4] & act[5]);
      fire = up_ok & dn_ok & (st_r.holdoff == '0);
      st_nxt.trig = fire;
      if (fire)
      begin
         st_nxt.holdoff = TCD_TRIG_SPACE - 1'b1;
         st_nxt.trig_cnt = st_r.trig_cnt + 1'b1;
         for (int i = 0; i < TCD_NCH; i++)
         begin
            if (act[i])
               st_nxt.coin_cnt[i] = st_r.coin_cnt[i] + 1'b1;
         end
      end
      else if (st_r.holdoff != '0)
         st_nxt.holdoff = st_r.holdoff - 1'b1;

      // ************************************************************
      // Threshold DAC writer, one frame per channel
      // ************************************************************
      unique case (st_r.dac_st)
         DAC_IDLE:
         begin
            st_nxt.dac.cs_n = 1'b1;
            st_nxt.dac.sclk = 1'b0;
            if (THR_LOAD)
            begin
               st_nxt.dac_ch = '0;
               st_nxt.dac_st = DAC_LOAD;
            end
         end
         DAC_LOAD:
         begin
            // Threshold inputs are read here; hold them steady while busy
            thr = THR_VALUE[st_r.dac_ch];
            frm = {TCD_ADDR_W'(st_r.dac_ch), thr};
            st_nxt.dac_shreg = frm;
            st_nxt.dac.din = frm[TCD_FRAME_W-1];
            st_nxt.dac.cs_n = 1'b0;
            st_nxt.dac_bit = '0;
            st_nxt.dac_div = '0;
            st_nxt.dac_st = DAC_SHIFT;
         end
         DAC_SHIFT:
         begin
            st_nxt.dac_div = st_r.dac_div + 1'b1;
            st_nxt.dac.din = st_r.dac_shreg[TCD_FRAME_W-1];
            if (st_r.dac_div == TCD_DAC_DIV - 1'b1)
            begin
               st_nxt.dac_div = '0;
               if (!st_r.dac.sclk)
                  st_nxt.dac.sclk = 1'b1;
               else
               begin
                  st_nxt.dac.sclk = 1'b0;
                  st_nxt.dac_shreg = {st_r.dac_shreg[TCD_FRAME_W-2:0], 1'b0};
                  st_nxt.dac.din = st_r.dac_shreg[TCD_FRAME_W-2];
                  st_nxt.dac_bit = st_r.dac_bit + 1'b1;
                  if (st_r.dac_bit == TCD_LAST_BIT)
                  begin
                     st_nxt.dac.cs_n = 1'b1;
                     if (st_r.dac_ch == TCD_LAST_CH)
                        st_nxt.dac_st = DAC_IDLE;
                     else
                     begin
                        st_nxt.dac_ch = st_r.dac_ch + 1'b1;
                        st_nxt.dac_st = DAC_LOAD;
                     end
                  end
               end
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         st_r <= '0;
         st_r.dac_st <= DAC_IDLE;
         st_r.dac.cs_n <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign TRIG_OUT = st_r.trig;
   assign HIT = st_r.hit;
   assign HIT_COUNT = st_r.hit_cnt;
   assign COINC_COUNT = st_r.coin_cnt;
   assign TRIG_COUNT = st_r.trig_cnt;
   assign DAC = st_r.dac;
   assign DAC_BUSY = (st_r.dac_st != DAC_IDLE);
   assign PIX_RX_DATA = st_r.pix_filt;
endmodule : tcd_top

/* File: tb/tcd_top_properties.sv */
// Port checker for the trigger coincidence timing block
module tcd_top_checker
   import tcd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic TRIG_OUT,
   input wire tcd_hit_s HIT,
   input wire tcd_cnt_t HIT_COUNT,
   input wire logic [TCD_CNT_W-1:0] TRIG_COUNT,
   input wire tcd_dac_s DAC,
   input wire logic DAC_BUSY
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   property p_trig_space; TRIG_OUT |=> !TRIG_OUT [*4]; endproperty
   property p_trig_cnt; TRIG_OUT |-> TRIG_COUNT == $past(TRIG_COUNT) + 24'h1; endproperty
   property p_hit0; HIT.valid[0] |-> HIT_COUNT[0] == $past(HIT_COUNT[0]) + 24'h1; endproperty
   property p_hit5; HIT.valid[5] |-> HIT_COUNT[5] == $past(HIT_COUNT[5]) + 24'h1; endproperty
   property p_hit_pulse; HIT.valid[2] |=> !HIT.valid[2]; endproperty
   property p_cs_busy; $fell(DAC.cs_n) |-> DAC_BUSY; endproperty
   property p_dac_idle; !DAC_BUSY |-> DAC.cs_n && !DAC.sclk; endproperty
   property p_sclk_hi; $rose(DAC.sclk) |-> DAC.sclk [*4] ##1 !DAC.sclk; endproperty
   property p_din_hold; DAC.sclk |-> $stable(DAC.din); endproperty
   a_trig_space: assert property (p_trig_space) else $error("trigger too soon");
   a_trig_cnt: assert property (p_trig_cnt) else $error("trigger count");
   a_hit0: assert property (p_hit0) else $error("hit count 0");
   a_hit5: assert property (p_hit5) else $error("hit count 5");
   a_hit_pulse: assert property (p_hit_pulse) else $error("hit pulse long");
   a_cs_busy: assert property (p_cs_busy) else $error("select while idle");
   a_dac_idle: assert property (p_dac_idle) else $error("dac pins idle");
   a_sclk_hi: assert property (p_sclk_hi) else $error("sclk high time");
   a_din_hold: assert property (p_din_hold) else $error("din moved");
   c_trig: cover property (TRIG_OUT);
   c_load: cover property ($fell(DAC.cs_n));
   c_hit: cover property (HIT.valid[5]);
endmodule : tcd_top_checker
bind tcd_top tcd_top_checker u_tcd_top_checker (.MCLK(MCLK), .RESET(RESET),
   .TRIG_OUT(TRIG_OUT), .HIT(HIT), .HIT_COUNT(HIT_COUNT), .TRIG_COUNT(TRIG_COUNT),
   .DAC(DAC), .DAC_BUSY(DAC_BUSY));

/* File: tb/tcd_front_model.sv */
// Discriminator front end and threshold DAC model
module tcd_front_model
   import tcd_pkg::*;
(
   input wire logic mclk,
   input wire logic fire,
   input wire logic [TCD_NCH-1:0] early,
   input wire logic [TCD_NCH-1:0] late,
   input wire tcd_dac_s dac,
   output logic [TCD_NCH-1:0] disc,
   output logic [TCD_FRAME_W-1:0] frame [TCD_NCH],
   output int n_frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [TCD_FRAME_W-1:0] sh = '0;
   int nb = 0;
   int nf = 0;
   assign n_frames = nf;
   // Early lines rise before a rising edge, late ones before the falling edge
   initial
   begin
      disc = '0;
      forever
      begin
         @(posedge mclk);
         if (fire)
         begin
            #40 disc = early;
            #25 disc = early | late;
            #150 disc = '0;
         end
      end
   end
   // Select low starts a frame, a clock rise takes a bit, select high ends it
   always @(negedge dac.cs_n or posedge dac.sclk or posedge dac.cs_n)
   begin
      if (dac.cs_n)
      begin
         // A frame counts only when all sixteen bits arrived
         if (nb == TCD_FRAME_W)
         begin
            frame[nf % TCD_NCH] = sh;
            nf++;
         end
         nb = 0;
      end
      else if (dac.sclk)
      begin
         sh = {sh[TCD_FRAME_W-2:0], dac.din};
         nb++;
      end
      else
         nb = 0;
   end
endmodule : tcd_front_model

/* File: tb/tb_trigger_coincidence_timing.sv */
// Self-checking bench for the trigger coincidence timing block
module tb_trigger_coincidence_timing
   import tcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, reset = 1'b1, acc = 1'b0, thr_load = 1'b0, pix = 1'b0, fire = 1'b0;
   tcd_delay_t dly = '0;
   tcd_thr_t thr = '0;
   logic [TCD_NCH-1:0] early = '0, late = '0, disc;
   logic trig_out, dac_busy, pix_data;
   tcd_hit_s hit;
   tcd_cnt_t hit_cnt, coinc_cnt;
   logic [TCD_CNT_W-1:0] trig_cnt, e_trig = '0;
   logic [TCD_CNT_W-1:0] e_hit [TCD_NCH] = '{default: '0}, e_coinc [TCD_NCH] = '{default: '0};
   tcd_dac_s dac;
   logic [TCD_FRAME_W-1:0] frame [TCD_NCH];
   int n_frames, n_fail = 0, n_compared = 0;
   logic [31:0] seed = 32'hde163b96;
   always #25 mclk = ~mclk;
   tcd_top u_tcd_top (.MCLK(mclk), .RESET(reset), .DISC_IN(disc), .ACC_CLK_IN(acc),
      .CH_DELAY(dly), .THR_VALUE(thr), .THR_LOAD(thr_load), .PIX_RX_IN(pix),
      .TRIG_OUT(trig_out), .HIT(hit), .HIT_COUNT(hit_cnt), .COINC_COUNT(coinc_cnt),
      .TRIG_COUNT(trig_cnt), .DAC(dac), .DAC_BUSY(dac_busy), .PIX_RX_DATA(pix_data));
   tcd_front_model u_tcd_front_model (.mclk(mclk), .fire(fire), .early(early), .late(late),
      .dac(dac), .disc(disc), .frame(frame), .n_frames(n_frames));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic f_trig(input logic [5:0] m);
      return ($countones(m[2:0]) >= 2) && ($countones(m[5:3]) >= 2);
   endfunction : f_trig
   task automatic chk(input logic [TCD_CNT_W-1:0] g, input logic [TCD_CNT_W-1:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic complete_run;
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // Pulse lasts well under the wait, so every shot is a fresh leading edge
   task automatic shot(input logic [5:0] e, input logic [5:0] l);
      early <= e;
      late <= l;
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (24) @(posedge mclk);
   endtask : shot
   initial
   begin
      logic [5:0] m;
      logic t;
      logic [5:0] corner [4] = '{6'h1b, 6'h0f, 6'h3f, 6'h2d};
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk(24'(dac.cs_n), 24'h1);
      acc <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         seed = xs(seed);
         m = (i < 4) ? corner[i] : seed[5:0];
         pix <= seed[8];
         dly <= {TCD_NCH{seed[12:9]}};
         shot(m, '0);
         t = f_trig(m);
         e_trig += t;
         for (int c = 0; c < TCD_NCH; c++)
         begin
            e_hit[c] += m[c];
            e_coinc[c] += m[c] & t;
            chk(hit_cnt[c], e_hit[c]);
            chk(coinc_cnt[c], e_coinc[c]);
         end
         chk(trig_cnt, e_trig);
         chk(24'(pix_data), 24'(pix));
      end
      // Half a tick plus three ticks of offset difference, in half-tick steps
      dly <= {16'h0, 4'h5, 4'h2};
      shot(6'h01, 6'h02);
      chk(24'(TCD_TS1_W'(hit.stamp[1] - hit.stamp[0])), 24'h7);
      e_hit[0] += 1'b1;
      e_hit[1] += 1'b1;
      // Staggered offsets make a second coincidence two ticks after the first
      dly <= {4'h4, 4'h2, 4'h0, 4'h4, 4'h2, 4'h0};
      shot(6'h3f, 6'h00);
      e_trig += 1'b1;
      for (int c = 0; c < TCD_NCH; c++)
      begin
         e_hit[c] += 1'b1;
         e_coinc[c] += (c % TCD_NSIDE != 2);
         chk(hit_cnt[c], e_hit[c]);
         chk(coinc_cnt[c], e_coinc[c]);
      end
      chk(trig_cnt, e_trig);
      for (int c = 0; c < TCD_NCH; c++)
      begin
         seed = xs(seed);
         thr[c] <= seed[TCD_THR_W-1:0];
      end
      thr_load <= 1'b1;
      @(posedge mclk);
      thr_load <= 1'b0;
      repeat (20) @(posedge mclk);
      thr_load <= 1'b1;
      @(posedge mclk);
      thr_load <= 1'b0;
      for (int k = 0; k < 2000 && dac_busy; k++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk(24'(dac_busy), 24'h0);
      chk(24'(n_frames), 24'h6);
      for (int c = 0; c < TCD_NCH; c++)
         chk(24'({c[3:0], thr[c]}), 24'(frame[c]));
      complete_run();
   end
endmodule : tb_trigger_coincidence_timing
